// ### design/hofc_core.sv
// output control and protection logic of the h-bridge driver
`timescale 1ns/1ns
`default_nettype none
`include "hofc_cfg.svh"
module hofc_core
   import hofc_pkg::*;
(
   // clock, reset, enable
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic clk_en_i,
   // pins and analog comparators, asynchronous
   input wire hofc_pins_t pins_i,
   input wire hofc_sense_t sense_i,
   // configuration, clear strobes and open-load check request
   input wire hofc_cfg_t cfg_i,
   input wire logic clr_fault_i,
   input wire hofc_flags_t clr_flag_i,
   input wire logic ol_request_i,
   // bridge legs and status
   output logic bridge_leg_a_o,
   output logic bridge_leg_a_oe_o,
   output logic bridge_leg_b_o,
   output logic bridge_leg_b_oe_o,
   output logic fault_status_pin_n_o,
   output var hofc_flags_t flags_o,
   output var hofc_state_t state_o
);
   localparam int OT_CYC = `HOFC_THERMAL_FILTER_CYC;
   localparam int OL_CYC = `HOFC_OL_CHECK_CYC;

   logic rst_meta;
   logic rst_b;
   hofc_pins_t pin_s1, pin_s2, pin_s3, pin_q;
   hofc_sense_t sen_s1, sen_s2, sen_s3, sen_q;
   logic kill_prev;
   logic wake_prev;
   hofc_state_t state;
   hofc_state_t next_state;
   logic [`HOFC_CNT_W-1:0] ot_cnt;
   logic [`HOFC_CNT_W-1:0] next_ot_cnt;
   logic [`HOFC_CNT_W-1:0] ol_cnt;
   hofc_flags_t flag;
   hofc_flags_t next_flag;

   // reset release through two flip-flops
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rst_meta <= 1'b0;
         rst_b <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_b <= rst_meta;
      end
   end

   // three-stage synchronisers; open pins resolve through pad pulls
   always_ff @(posedge ref_clk_i or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_s1 <= `HOFC_PINS_RST;
         pin_s2 <= `HOFC_PINS_RST;
         pin_s3 <= `HOFC_PINS_RST;
         sen_s1 <= `HOFC_SENSE_RST;
         sen_s2 <= `HOFC_SENSE_RST;
         sen_s3 <= `HOFC_SENSE_RST;
      end
      else if (clk_en_i)
      begin
         pin_s1 <= pins_i;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         sen_s1 <= sense_i;
         sen_s2 <= sen_s1;
         sen_s3 <= sen_s2;
      end
   end

   // a bit changes only when stages two and three agree
   wire [3:0] pin_agree = ~(pin_s2 ^ pin_s3);
   wire [7:0] sen_agree = ~(sen_s2 ^ sen_s3);
   wire [3:0] next_pin = (pin_agree & pin_s3) | (~pin_agree & pin_q);
   wire [7:0] next_sen = (sen_agree & sen_s3) | (~sen_agree & sen_q);

   always_ff @(posedge ref_clk_i or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_q <= `HOFC_PINS_RST;
         sen_q <= `HOFC_SENSE_RST;
         kill_prev <= 1'b1;
         wake_prev <= 1'b0;
      end
      else if (clk_en_i)
      begin
         pin_q <= next_pin;
         sen_q <= next_sen;
         kill_prev <= pin_q.kill_input;
         wake_prev <= pin_q.wake_pin;
      end
   end

   // device state and release of latched faults
   wire awake = pin_q.wake_pin;
   wire asleep = (state == HOFC_SLEEP);
   wire pin_toggle = (pin_q.kill_input ^ kill_prev) |
                     (pin_q.wake_pin ^ wake_prev);
   wire latch_clr = clr_fault_i | pin_toggle;
   wire ol_done = (state == HOFC_OLCHK) &&
                  (ol_cnt == `HOFC_CNT_W'(OL_CYC - 1));

   // sleep, open-load check, run
   always_comb
   begin
      next_state = state;
      unique case (state)
         HOFC_SLEEP:
            if (awake)
               next_state = HOFC_OLCHK;
         HOFC_OLCHK:
            if (!awake)
               next_state = HOFC_SLEEP;
            else if (ol_done)
               next_state = HOFC_RUN;
         HOFC_RUN:
            if (!awake)
               next_state = HOFC_SLEEP;
            else if (ol_request_i)
               next_state = HOFC_OLCHK;
         default:
            next_state = HOFC_SLEEP;
      endcase
   end

   assign next_ot_cnt = !sen_q.overheat || asleep ? '0 :
                        ot_cnt == `HOFC_CNT_W'(OT_CYC) ? ot_cnt :
                        ot_cnt + `HOFC_CNT_W'(1);
   wire ot_trip = (ot_cnt == `HOFC_CNT_W'(OT_CYC));

   always_ff @(posedge ref_clk_i or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= HOFC_SLEEP;
         ot_cnt <= '0;
         ol_cnt <= '0;
      end
      else if (clk_en_i)
      begin
         state <= next_state;
         ot_cnt <= next_ot_cnt;
         ol_cnt <= (state == HOFC_OLCHK) ? ol_cnt + `HOFC_CNT_W'(1) : '0;
      end
   end

   // flag updates; a set in the clearing cycle wins
   always_comb
   begin
      next_flag = flag;
      if ((latch_clr || clr_flag_i.overheat_shutdown_flag) &&
          !sen_q.overheat)
         next_flag.overheat_shutdown_flag = 1'b0;
      if (ot_trip)
         next_flag.overheat_shutdown_flag = 1'b1;
      next_flag.heat_warning_flag = sen_q.heat_warn && !asleep;
      if (clr_fault_i || clr_flag_i.overcurrent_flag)
         next_flag.overcurrent_flag = 1'b0;
      if (sen_q.overcurrent && !asleep)
         next_flag.overcurrent_flag = 1'b1;
      if (clr_fault_i || clr_flag_i.load_missing_flag)
         next_flag.load_missing_flag = 1'b0;
      if (ol_done && sen_q.load_open)
         next_flag.load_missing_flag = 1'b1;
      if ((clr_fault_i || clr_flag_i.supply_high_flag) &&
          !sen_q.supply_high)
         next_flag.supply_high_flag = 1'b0;
      if (sen_q.supply_high && !asleep)
         next_flag.supply_high_flag = 1'b1;
      if ((clr_fault_i || clr_flag_i.supply_low_flag) &&
          !sen_q.supply_low)
         next_flag.supply_low_flag = 1'b0;
      if (sen_q.supply_low && !asleep)
         next_flag.supply_low_flag = 1'b1;
      if (latch_clr || clr_flag_i.short_a_flag)
         next_flag.short_a_flag = 1'b0;
      if (sen_q.short_a && bridge_leg_a_oe_o)
         next_flag.short_a_flag = 1'b1;
      if (latch_clr || clr_flag_i.short_b_flag)
         next_flag.short_b_flag = 1'b0;
      if (sen_q.short_b && bridge_leg_b_oe_o)
         next_flag.short_b_flag = 1'b1;
   end

   // input selection and bridge decode
   // virtual inputs replace pins
   wire sel_a = cfg_i.input_src ? cfg_i.virtual_drive_a : pin_q.drive_input_a;
   wire sel_b = cfg_i.input_src ? cfg_i.virtual_drive_b : pin_q.drive_input_b;
   wire hmode = cfg_i.bridge_mode;
   // h-bridge steering by a and b
   wire norm_a = hmode ? (!sel_b || sel_a) : sel_a;
   wire norm_b = hmode ? (!sel_b || !sel_a) : sel_b;
   wire ov_force = hmode && sen_q.supply_high && !asleep;
   wire val_a = ov_force || norm_a;
   wire val_b = ov_force || norm_b;
   wire drive_en = awake && !pin_q.kill_input && cfg_i.out_allow &&
                   !sen_q.supply_low && !flag.overheat_shutdown_flag;
   wire sc_any = flag.short_a_flag || flag.short_b_flag;
   wire oe_a = drive_en && !(hmode ? sc_any : flag.short_a_flag);
   wire oe_b = drive_en && !(hmode ? sc_any : flag.short_b_flag);
   wire held = flag.overheat_shutdown_flag || sc_any ||
               flag.supply_low_flag || flag.supply_high_flag;
   wire fs_n = !awake || !(pin_q.kill_input || (held && !cfg_i.fs_mask));

   // registered outputs and flags
   always_ff @(posedge ref_clk_i or negedge rst_b)
   begin
      if (!rst_b)
      begin
         flag <= `HOFC_FLAGS_RST;
         bridge_leg_a_o <= 1'b0;
         bridge_leg_b_o <= 1'b0;
         bridge_leg_a_oe_o <= 1'b0;
         bridge_leg_b_oe_o <= 1'b0;
         fault_status_pin_n_o <= 1'b1;
      end
      else if (clk_en_i)
      begin
         flag <= next_flag;
         bridge_leg_a_o <= oe_a && val_a;
         bridge_leg_b_o <= oe_b && val_b;
         bridge_leg_a_oe_o <= oe_a;
         bridge_leg_b_oe_o <= oe_b;
         fault_status_pin_n_o <= fs_n;
      end
   end

   assign flags_o = flag;
   assign state_o = state;

   // checks on the protection and decode behaviour
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b);

   sequence s_step;
      clk_en_i;
   endsequence
   sequence s_clean_run;
      clk_en_i && drive_en && !sc_any;
   endsequence
   sequence s_hot_filtered;
      clk_en_i && ot_trip;
   endsequence

   a_ot_latch_set: assert property (
      s_hot_filtered ##1 s_step
      |-> flag.overheat_shutdown_flag ##1
          (!bridge_leg_a_oe_o && !bridge_leg_b_oe_o))
      else $error("overheat trip did not latch off");
   a_ot_hold: assert property (
      clk_en_i && flag.overheat_shutdown_flag && sen_q.overheat
      |=> flag.overheat_shutdown_flag)
      else $error("overheat latch cleared while hot");
   a_half_follow: assert property (
      s_clean_run and (!hmode) |=> bridge_leg_a_o == $past(sel_a) &&
                                   bridge_leg_b_o == $past(sel_b))
      else $error("half-bridge legs do not follow inputs");
   a_hb_steer: assert property (
      s_clean_run and (hmode && !sen_q.supply_high && sel_b)
      |=> bridge_leg_a_o != bridge_leg_b_o &&
          bridge_leg_a_o == $past(sel_a))
      else $error("h-bridge steering wrong");
   a_hb_freewheel: assert property (
      s_clean_run and (hmode && !sel_b) |=> bridge_leg_a_o && bridge_leg_b_o)
      else $error("h-bridge freewheel high missing");
   a_kill_off: assert property (
      s_step and (awake && pin_q.kill_input)
      |=> !bridge_leg_a_oe_o && !bridge_leg_b_oe_o && !fault_status_pin_n_o)
      else $error("kill input did not disable legs");
   a_uv_pin_low: assert property (
      s_step and (flag.supply_low_flag && awake && !cfg_i.fs_mask)
      |=> !fault_status_pin_n_o)
      else $error("fault pin released while supply low held");
   a_ov_force: assert property (
      s_clean_run and (ov_force) |=> bridge_leg_a_o && bridge_leg_b_o)
      else $error("supply high did not force freewheel");
   a_sc_single: assert property (
      s_step and (!hmode && drive_en &&
                  (flag.short_a_flag != flag.short_b_flag))
      |=> bridge_leg_a_oe_o == !$past(flag.short_a_flag) &&
          bridge_leg_b_oe_o == !$past(flag.short_b_flag))
      else $error("half-bridge short scope wrong");
   a_tw_live: assert property (
      s_step |=> flag.heat_warning_flag == $past(sen_q.heat_warn && !asleep))
      else $error("heat warning not live");
   a_ol_entry: assert property (
      s_step and (asleep && awake) |=> state == HOFC_OLCHK)
      else $error("wake did not start open-load check");
   a_sleep_pins: assert property (
      s_step and (!awake) |=> !bridge_leg_a_oe_o && !bridge_leg_b_oe_o &&
                              fault_status_pin_n_o)
      else $error("sleep outputs wrong");
endmodule
`default_nettype wire

// ### design/hofc_cfg.svh
// timing counts, reset values and widths for the bridge control block
`ifndef HOFC_CFG_SVH
`define HOFC_CFG_SVH
`define HOFC_CLK_NS 100
`define HOFC_THERMAL_FILTER_NS 11000
`define HOFC_THERMAL_FILTER_CYC (`HOFC_THERMAL_FILTER_NS / `HOFC_CLK_NS)
`define HOFC_OL_CHECK_NS 2000
`define HOFC_OL_CHECK_CYC (`HOFC_OL_CHECK_NS / `HOFC_CLK_NS)
`define HOFC_CNT_W 8
`define HOFC_PINS_RST 4'h4
`define HOFC_SENSE_RST 8'h00
`define HOFC_FLAGS_RST 8'h00
`endif

// ### design/hofc_pkg.sv
// types shared by the bridge control block
package hofc_pkg;
   typedef enum logic [2:0] {
      HOFC_SLEEP = 3'h1,
      HOFC_OLCHK = 3'h2,
      HOFC_RUN = 3'h4
   } hofc_state_t;
   typedef struct packed {
      logic wake_pin;
      logic kill_input;
      logic drive_input_a;
      logic drive_input_b;
   } hofc_pins_t;
   typedef struct packed {
      logic out_allow;
      logic bridge_mode;
      logic input_src;
      logic virtual_drive_a;
      logic virtual_drive_b;
      logic fs_mask;
   } hofc_cfg_t;
   typedef struct packed {
      logic supply_low;
      logic supply_high;
      logic overheat;
      logic heat_warn;
      logic overcurrent;
      logic load_open;
      logic short_a;
      logic short_b;
   } hofc_sense_t;
   typedef struct packed {
      logic overheat_shutdown_flag;
      logic heat_warning_flag;
      logic overcurrent_flag;
      logic load_missing_flag;
      logic supply_high_flag;
      logic supply_low_flag;
      logic short_a_flag;
      logic short_b_flag;
   } hofc_flags_t;
endpackage

// ### testbench/hofc_host.sv
// host side model: board pulls on open pins and the fault clear pulse
`timescale 1ns/1ns
`default_nettype none
module hofc_host
   import hofc_pkg::*;
(
   // clock
   input wire logic ref_clk_i,
   // wanted levels, open pins, clear request
   input wire hofc_pins_t want_i,
   input wire logic [3:0] open_i,
   input wire logic clr_req_i,
   // toward the device
   output wire hofc_pins_t pins_o,
   output logic clr_fault_o
);
   // open pins settle to pulls: wake low, kill high, inputs low
   assign pins_o.wake_pin = open_i[3] ? 1'b0 : want_i.wake_pin;
   assign pins_o.kill_input = open_i[2] ? 1'b1 : want_i.kill_input;
   assign pins_o.drive_input_a = open_i[1] ? 1'b0 : want_i.drive_input_a;
   assign pins_o.drive_input_b = open_i[0] ? 1'b0 : want_i.drive_input_b;
   always_ff @(posedge ref_clk_i)
   begin
      clr_fault_o <= clr_req_i;
   end
endmodule
`default_nettype wire

// ### testbench/hbridge_output_fault_control_tb_top.sv
// self-checking bench for the bridge output and fault control block
`timescale 1ns/1ns
`default_nettype none
module hbridge_output_fault_control_tb_top import hofc_pkg::*;;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   hofc_pins_t want = 4'h0;
   logic [3:0] opn = 4'h0;
   hofc_sense_t sense = 8'h00;
   hofc_cfg_t cfg = 6'h30;
   logic clr_req = 1'b0;
   hofc_flags_t clr_flag = 8'h00;
   logic ol_req = 1'b0;
   logic clk_en = 1'b1;
   hofc_pins_t pins;
   logic clr_fault, leg_a, oe_a, leg_b, oe_b, fs_n;
   hofc_flags_t flags;
   hofc_state_t state;
   int mismatches = 0;
   int checks = 0;
   // 10 MHz clock
   always #50 ref_clk = ~ref_clk;
   hofc_host host (.ref_clk_i(ref_clk), .want_i(want), .open_i(opn),
      .clr_req_i(clr_req), .pins_o(pins), .clr_fault_o(clr_fault));
   hofc_core dut (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .clk_en_i(clk_en),
      .pins_i(pins), .sense_i(sense), .cfg_i(cfg), .clr_fault_i(clr_fault),
      .clr_flag_i(clr_flag), .ol_request_i(ol_req),
      .bridge_leg_a_o(leg_a), .bridge_leg_a_oe_o(oe_a),
      .bridge_leg_b_o(leg_b), .bridge_leg_b_oe_o(oe_b),
      .fault_status_pin_n_o(fs_n), .flags_o(flags), .state_o(state));
   task automatic print_verdict;
      if (mismatches == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // arguments: name, value seen, value expected
   task automatic chk(input string nm, input logic [7:0] g,
      input logic [7:0] e);
      checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // sample a little after the edge so its updates have landed
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #10;
   endtask
   // packed as oe_a, leg_a, oe_b, leg_b, fault pin
   task automatic legs(input logic [4:0] e);
      chk("legs", {3'h0, oe_a, leg_a, oe_b, leg_b, fs_n}, {3'h0, e});
   endtask
   task automatic pin_set(input logic [3:0] p, input logic [3:0] o);
      @(posedge ref_clk);
      want <= p;
      opn <= o;
      settle(8);
   endtask
   task automatic sns(input logic [7:0] s, input int n);
      @(posedge ref_clk);
      sense <= s;
      settle(n);
   endtask
   task automatic cfg_set(input logic [5:0] c);
      @(posedge ref_clk);
      cfg <= c;
      settle(3);
   endtask
   task automatic clr_all;
      @(posedge ref_clk);
      clr_req <= 1'b1;
      @(posedge ref_clk);
      clr_req <= 1'b0;
      settle(4);
   endtask
   task automatic clr_one(input logic [7:0] f);
      @(posedge ref_clk);
      clr_flag <= f;
      @(posedge ref_clk);
      clr_flag <= 8'h00;
      settle(3);
   endtask
   function automatic logic [1:0] steer(input logic m, a, b);
      if (!m)
         return {a, b};
      return b ? {a, ~a} : 2'h3;
   endfunction
   // every mode, source and input pair; the unused source is inverted
   task automatic t_steer;
      logic [1:0] e;
      logic va, vb;
      for (int k = 0; k < 16; k++)
      begin
         e = steer(k[3], k[1], k[0]);
         va = k[1] ~^ k[2];
         vb = k[0] ~^ k[2];
         @(posedge ref_clk);
         cfg <= {1'b1, k[3], k[2], va, vb, 1'b0};
         want <= {2'h2, ~va, ~vb};
         settle(8);
         legs({1'b1, e[1], 1'b1, e[0], 1'b1});
      end
      cfg_set(6'h20);
      pin_set(4'hB, 4'h2);
      legs(5'h17);
      cfg_set(6'h30);
      legs(5'h17);
      pin_set(4'hA, 4'h1);
      legs(5'h1F);
   endtask
   task automatic t_kill;
      pin_set(4'hE, 4'h0);
      legs(5'h00);
      pin_set(4'hA, 4'h4);
      legs(5'h00);
      pin_set(4'hA, 4'h0);
      cfg_set(6'h10);
      legs(5'h01);
      cfg_set(6'h30);
      pin_set(4'hA, 4'h8);
      legs(5'h01);
      chk("state", {5'h0, state}, {5'h0, HOFC_SLEEP});
      pin_set(4'hB, 4'h0);
      settle(40);
      chk("state", {5'h0, state}, {5'h0, HOFC_RUN});
      legs(5'h1D);
   endtask
   task automatic t_supply;
      sns(8'h80, 8);
      legs(5'h00);
      sns(8'h00, 8);
      legs(5'h1C);
      clr_all;
      legs(5'h1D);
      sns(8'h40, 8);
      legs(5'h1E);
      sns(8'h00, 8);
      legs(5'h1C);
      cfg_set(6'h31);
      chk("fs_n", {7'h0, fs_n}, 8'h01);
      cfg_set(6'h30);
      clr_all;
      legs(5'h1D);
      // virtual a low, b high: a forced freewheel would show as 11
      cfg_set(6'h2A);
      sns(8'h40, 8);
      chk("half", {6'h0, leg_a, leg_b}, 8'h01);
      sns(8'h00, 8);
      clr_all;
      cfg_set(6'h30);
   endtask
   task automatic t_heat;
      sns(8'h10, 8);
      chk("warn", {7'h0, flags.heat_warning_flag}, 8'h01);
      legs(5'h1D);
      sns(8'h00, 8);
      chk("warn", {7'h0, flags.heat_warning_flag}, 8'h00);
      sns(8'h20, 100);
      sns(8'h00, 8);
      legs(5'h1D);
      sns(8'h20, 125);
      chk("ot", {7'h0, flags.overheat_shutdown_flag}, 8'h01);
      legs(5'h00);
      clr_all;
      legs(5'h00);
      sns(8'h00, 8);
      legs(5'h00);
      clr_all;
      legs(5'h1D);
   endtask
   task automatic t_short;
      sns(8'h02, 3);
      sns(8'h00, 8);
      legs(5'h00);
      pin_set(4'hF, 4'h0);
      pin_set(4'hB, 4'h0);
      chk("oe", {6'h0, oe_a, oe_b}, 8'h03);
      clr_all;
      cfg_set(6'h20);
      sns(8'h01, 3);
      sns(8'h00, 8);
      legs(5'h18);
      clr_all;
      legs(5'h1F);
      cfg_set(6'h30);
   endtask
   task automatic t_flags;
      sns(8'h08, 4);
      sns(8'h00, 8);
      chk("oc", {7'h0, flags.overcurrent_flag}, 8'h01);
      legs(5'h1D);
      clr_one(8'h20);
      chk("oc", {7'h0, flags.overcurrent_flag}, 8'h00);
      sns(8'h04, 3);
      @(posedge ref_clk);
      ol_req <= 1'b1;
      @(posedge ref_clk);
      ol_req <= 1'b0;
      settle(40);
      sns(8'h00, 8);
      chk("ol", {7'h0, flags.load_missing_flag}, 8'h01);
      legs(5'h1D);
      clr_one(8'h10);
      chk("ol", {7'h0, flags.load_missing_flag}, 8'h00);
   endtask
   // clock enable low freezes state, so a kill only lands once it is back
   task automatic t_freeze;
      @(posedge ref_clk);
      clk_en <= 1'b0;
      want <= 4'hF;
      settle(8);
      legs(5'h1D);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      settle(8);
      legs(5'h00);
      pin_set(4'hB, 4'h0);
      legs(5'h1D);
   endtask
   // main sequence
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      settle(10);
      pin_set(4'h8, 4'h0);
      settle(40);
      t_steer;
      pin_set(4'hB, 4'h0);
      t_kill;
      t_supply;
      t_heat;
      t_short;
      t_flags;
      t_freeze;
      print_verdict;
   end
   // watchdog, far beyond the expected run
   initial
   begin
      #3000000;
      mismatches++;
      print_verdict;
   end
endmodule
`default_nettype wire
